// File: emo_top.sv
/*
 Object dictionary logic of the encoder: speed and acceleration objects,
 legacy unlock, loader trigger, operating word, scaling, preset, position
 and the second transmit PDO mapping. Assumes an SDO server in front that
 presents one object access at a time and waits for od_ack.
*/
`timescale 1ns/1ps
module emo_top #(
  parameter int unsigned MS_CYC     = emo_pkg::MS_CYCLES,
  parameter int unsigned NATIVE_BITS = 16,
  parameter logic [31:0] STEPS_DEF  = 32'h0001_0000,
  parameter logic [31:0] RANGE_DEF  = 32'h0000_0000,
  // Loader key value is arbitrary.
  parameter logic [31:0] LOADER_KEY = 32'h1234_5678
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Object access
  input  wire logic        od_req,
  input  wire logic        od_write,
  input  wire logic        od_restore,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_sub,
  input  wire logic [31:0] od_wdata,
  output logic             od_ack,
  output logic             od_abort,
  output logic [31:0]      od_abort_code,
  output logic [31:0]      od_rdata,
  // Sensor and start-up
  input  wire logic [31:0] raw_pos,
  input  wire logic        app_valid,
  input  wire logic [6:0]  cfg_node_id,
  input  wire logic [7:0]  cfg_baud,
  // Status and controls
  output logic [6:0]       node_id,
  output logic [7:0]       baud_code,
  output logic             loader_mode,
  output logic             nv_erase,
  output logic             dev_reset_req,
  output logic             legacy_compat_mode,
  // Process values
  output logic [31:0]      position_out,
  output logic [31:0]      speed_32,
  output logic [15:0]      speed_16,
  output logic [31:0]      accel_32,
  // Transmit PDO 2 setup
  output logic [7:0]       tpdo2_ttype,
  output logic [15:0]      tpdo2_etimer,
  output logic [7:0]       tpdo2_count,
  output logic [31:0]      first_mapping_entry
);
  import emo_pkg::*;

  emo_rate_if spd_if ();
  emo_rate_if acc_if ();

  emo_ld_state_t ld_q;
  logic [15:0] ms_cnt_q;
  logic        ms_tick_q;
  logic        boot_seen_q;
  logic        loader_q;
  logic        unlock_q;
  logic        legacy_q;
  logic [7:0]  spd_en_q, spd_mode_q, acc_en_q, acc_mode_q;
  logic [15:0] opw_q;
  logic [31:0] steps_q, range_q, preset_q, offset_q, pos_q;
  logic [15:0] spd16_q;
  logic [7:0]  ttype_q, map_cnt_q;
  logic [15:0] etimer_q;
  logic [31:0] map_ent_q;
  logic        ack_q, abort_q, erase_q, reset_q;
  logic [31:0] rdata_q, abcode_q;
  logic [6:0]  node_q;
  logic [7:0]  baud_q;
  logic [31:0] rd_d, ab_d;

  // Millisecond enable shared by both rate units.
  wire ms_wrap = (ms_cnt_q == 16'(MS_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ms_cnt_q  <= 16'h0000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_cnt_q  <= ms_wrap ? 16'h0000 : ms_cnt_q + 16'd1;
      ms_tick_q <= ms_wrap;
    end
  end

  // Position path: direction, optional scaling, then preset offset.
  wire [31:0] dir_pos  = opw_q[OPW_DIR] ? 32'h0 - raw_pos : raw_pos;
  wire [63:0] scl_prod = {32'h0, dir_pos} * {32'h0, steps_q};
  wire [31:0] scl_raw  = scl_prod[NATIVE_BITS +: 32];
  wire        rng_ok   = (range_q != 32'h0);
  wire [31:0] scl_pos  = rng_ok ? scl_raw % range_q : scl_raw;
  wire [31:0] base_pos = opw_q[OPW_SCALE] ? scl_pos : dir_pos;
  wire [32:0] pos_sum  = {1'b0, base_pos} + {1'b0, offset_q};
  wire        pos_wrap = rng_ok && opw_q[OPW_SCALE] &&
                         (pos_sum >= {1'b0, range_q});
  wire [32:0] pos_sub  = pos_sum - {1'b0, range_q};
  wire [31:0] pos_d    = pos_wrap ? pos_sub[31:0] : pos_sum[31:0];
  // The offset makes the current position read back as the preset.
  wire        pre_ge   = (od_wdata >= base_pos);
  wire        pre_mod  = rng_ok && opw_q[OPW_SCALE] && !pre_ge;
  wire [31:0] off_d    = pre_mod ? od_wdata + range_q - base_pos
                                 : od_wdata - base_pos;

  // Speed saturation to the 16-bit object.
  wire [31:0] s32    = spd_if.dout;
  wire        s_hi   = !s32[31] && (s32[30:15] != 16'h0000);
  wire        s_lo   = s32[31] && (s32[30:15] != 16'hffff);
  wire [15:0] spd16_d = s_hi ? 16'h7fff : s_lo ? 16'h8000 : s32[15:0];

  // Rate unit hookup; the loader stops all measurement.
  assign spd_if.ms_tick = ms_tick_q;
  assign spd_if.en      = (spd_en_q != 8'h00) && !loader_q;
  assign spd_if.mode    = spd_mode_q;
  assign spd_if.din     = pos_q;
  assign acc_if.ms_tick = ms_tick_q;
  assign acc_if.en      = (acc_en_q != 8'h00) && !loader_q;
  assign acc_if.mode    = acc_mode_q;
  assign acc_if.din     = spd_if.dout;

  emo_rate #(
    .DLY0 (SPD_DLY0_MS),
    .DLY1 (SPD_DLY1_MS),
    .DLY2 (SPD_DLY2_MS)
  ) u_spd (
    .core_clk (core_clk),
    .srst     (srst),
    .rif      (spd_if.meas)
  );

  emo_rate #(
    .DLY0 (ACC_DLY0_MS),
    .DLY1 (ACC_DLY1_MS),
    .DLY2 (ACC_DLY2_MS)
  ) u_acc (
    .core_clk (core_clk),
    .srst     (srst),
    .rif      (acc_if.meas)
  );

  // Access decode.
  wire wr      = od_req && od_write;
  wire s0      = (od_sub == SUB_0);
  wire s1      = (od_sub == SUB_1);
  wire s2      = (od_sub == SUB_2);
  wire filt_ok = (od_wdata[7:0] <= FILT_MAX);
  wire comm    = (od_index[15:12] == COMM_AREA);
  wire hidden  = loader_q && !comm;
  wire acc_ok  = od_req && (ab_d == AB_NONE);
  wire we      = acc_ok && od_write;
  wire hit_opw = (od_index == OBJ_OPWORD);
  wire hit_vop = (od_index == OBJ_VOPWORD);
  wire hit_stp = (od_index == OBJ_STEPS) || (od_index == OBJ_VSTEPS);

  always_comb begin
    rd_d = 32'h0000_0000;
    ab_d = AB_NONE;
    if (hidden) begin
      ab_d = AB_NO_OBJ;
    end else begin
      case (od_index)
        OBJ_SPD_CTRL, OBJ_ACC_CTRL: begin
          if (s0) begin
            rd_d = {24'h0, CTRL_SUBS};
            ab_d = od_write ? AB_RO : AB_NONE;
          end else if (s1) begin
            rd_d = {24'h0, (od_index == OBJ_SPD_CTRL) ? spd_en_q : acc_en_q};
          end else if (s2) begin
            rd_d = {24'h0, (od_index == OBJ_SPD_CTRL) ? spd_mode_q
                                                       : acc_mode_q};
            ab_d = (od_write && !filt_ok) ? AB_RANGE : AB_NONE;
          end else begin
            ab_d = AB_NO_SUB;
          end
        end
        OBJ_SPD32, OBJ_ACC32: begin
          rd_d = (od_index == OBJ_SPD32) ? spd_if.dout : acc_if.dout;
          ab_d = od_write ? AB_RO : (s0 ? AB_NONE : AB_NO_SUB);
        end
        OBJ_LEGACY: begin
          if (s0) begin
            rd_d = LEGACY_KEY;
            ab_d = (od_write && od_wdata != LEGACY_KEY) ? AB_RANGE : AB_NONE;
          end else if (s1) begin
            rd_d = {31'h0, legacy_q};
            ab_d = (od_write && !unlock_q && !od_restore) ? AB_STATE
                                                          : AB_NONE;
          end else begin
            ab_d = AB_NO_SUB;
          end
        end
        OBJ_LOADER: begin
          ab_d = !od_write ? AB_WO :
                 (od_wdata != LOADER_KEY) ? AB_RANGE : AB_NONE;
        end
        OBJ_OPWORD, OBJ_VOPWORD: begin
          rd_d = hit_opw ? {16'h0, opw_q & OPW_MASK}
                         : {31'h0, opw_q[OPW_DIR]};
          ab_d = s0 ? AB_NONE : AB_NO_SUB;
        end
        OBJ_STEPS, OBJ_VSTEPS, OBJ_RANGE, OBJ_PRESET: begin
          rd_d = hit_stp ? steps_q :
                 (od_index == OBJ_RANGE) ? range_q : preset_q;
          ab_d = s0 ? AB_NONE : AB_NO_SUB;
        end
        OBJ_POS, OBJ_VPOS: begin
          rd_d = pos_q;
          ab_d = od_write ? AB_RO : (s0 ? AB_NONE : AB_NO_SUB);
        end
        OBJ_SPD16: begin
          rd_d = s0 ? {24'h0, SPD16_SUBS} : {{16{spd16_q[15]}}, spd16_q};
          ab_d = od_write ? AB_RO : ((s0 || s1) ? AB_NONE : AB_NO_SUB);
        end
        OBJ_TPDO2_COMM: begin
          rd_d = s2 ? {24'h0, ttype_q} : {16'h0, etimer_q};
          ab_d = (s2 || od_sub == SUB_ETIMER) ? AB_NONE : AB_NO_SUB;
        end
        OBJ_TPDO2_MAP: begin
          rd_d = s0 ? {24'h0, map_cnt_q} : map_ent_q;
          if (s0) begin
            ab_d = (od_write && od_wdata[7:0] > MAP_MAX) ? AB_RANGE : AB_NONE;
          end else if (s1) begin
            ab_d = (od_write && map_cnt_q != 8'h00) ? AB_STATE
                                                    : AB_NONE;
          end else begin
            ab_d = AB_NO_SUB;
          end
        end
        default: ab_d = AB_NO_OBJ;
      endcase
    end
  end

  // Control objects.
  wire we_spd = we && (od_index == OBJ_SPD_CTRL);
  wire we_acc = we && (od_index == OBJ_ACC_CTRL);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      spd_en_q   <= CTRL_RESET;
      spd_mode_q <= CTRL_RESET;
      acc_en_q   <= CTRL_RESET;
      acc_mode_q <= CTRL_RESET;
    end else begin
      if (we_spd && s1) spd_en_q <= od_wdata[7:0];
      if (we_spd && s2) spd_mode_q <= od_wdata[7:0];
      if (we_acc && s1) acc_en_q <= od_wdata[7:0];
      if (we_acc && s2) acc_mode_q <= od_wdata[7:0];
    end
  end

  // Legacy unlock; the key only opens the flag, it is not stored.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      unlock_q <= 1'b0;
      legacy_q <= 1'b0;
    end else begin
      if (we && od_index == OBJ_LEGACY && s0) unlock_q <= 1'b1;
      if (we && od_index == OBJ_LEGACY && s1) legacy_q <= od_wdata[0];
    end
  end

  // Scaling and operating parameters.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      opw_q    <= OPW_RESET;
      steps_q  <= STEPS_DEF;
      range_q  <= RANGE_DEF;
      preset_q <= PRESET_RESET;
      offset_q <= PRESET_RESET;
    end else begin
      if (we && hit_opw) opw_q <= od_wdata[15:0] & OPW_MASK;
      if (we && hit_vop) opw_q[OPW_DIR] <= od_wdata[0];
      if (we && hit_stp) steps_q <= od_wdata;
      if (we && od_index == OBJ_RANGE) range_q <= od_wdata;
      if (we && od_index == OBJ_PRESET) begin
        preset_q <= od_wdata;
        offset_q <= off_d;
      end
    end
  end

  // Transmit PDO 2 setup.
  wire we_map = we && (od_index == OBJ_TPDO2_MAP);
  wire we_com = we && (od_index == OBJ_TPDO2_COMM);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ttype_q   <= 8'h00;
      etimer_q  <= 16'h0000;
      map_cnt_q <= 8'h00;
      map_ent_q <= 32'h0000_0000;
    end else begin
      if (we_com && s2) ttype_q <= od_wdata[7:0];
      if (we_com && od_sub == SUB_ETIMER) etimer_q <= od_wdata[15:0];
      if (we_map && s0) map_cnt_q <= od_wdata[7:0];
      if (we_map && s1) map_ent_q <= od_wdata;
    end
  end

  // Start-up capture and loader sequence. The application check is taken
  // in the first cycle after reset so that it is never a reset value.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      boot_seen_q <= 1'b0;
      loader_q    <= 1'b0;
      ld_q        <= LD_RUN;
      erase_q     <= 1'b0;
      reset_q     <= 1'b0;
    end else begin
      // Flags track the state one for one so that the pins leave flip-flops.
      erase_q     <= (ld_q == LD_RUN) && we && (od_index == OBJ_LOADER);
      reset_q     <= (ld_q != LD_RUN);
      if (!boot_seen_q) begin
        boot_seen_q <= 1'b1;
        loader_q    <= !app_valid;
      end
      case (ld_q)
        LD_RUN:   if (we && od_index == OBJ_LOADER) ld_q <= LD_ERASE;
        LD_ERASE: ld_q <= LD_RESET;
        LD_RESET: ld_q <= LD_RESET;
        default:  ld_q <= LD_RUN;
      endcase
    end
  end

  // Registered outputs and access answer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      node_q   <= LOADER_NODE;
      baud_q   <= LOADER_BAUD;
      pos_q    <= 32'h0000_0000;
      spd16_q  <= 16'h0000;
      ack_q    <= 1'b0;
      abort_q  <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      abcode_q <= AB_NONE;
    end else begin
      node_q   <= loader_q ? LOADER_NODE : cfg_node_id;
      baud_q   <= loader_q ? LOADER_BAUD : cfg_baud;
      if (!loader_q) pos_q <= pos_d;
      spd16_q  <= spd16_d;
      ack_q    <= od_req;
      abort_q  <= od_req && (ab_d != AB_NONE);
      rdata_q  <= (od_req && !od_write && ab_d == AB_NONE) ? rd_d : 32'h0;
      abcode_q <= od_req ? ab_d : AB_NONE;
    end
  end

  assign od_ack              = ack_q;
  assign od_abort            = abort_q;
  assign od_abort_code       = abcode_q;
  assign od_rdata            = rdata_q;
  assign node_id             = node_q;
  assign baud_code           = baud_q;
  assign loader_mode         = loader_q;
  assign nv_erase            = erase_q;
  assign dev_reset_req       = reset_q;
  assign legacy_compat_mode  = legacy_q;
  assign position_out        = pos_q;
  assign speed_32            = spd_if.dout;
  assign speed_16            = spd16_q;
  assign accel_32            = acc_if.dout;
  assign tpdo2_ttype         = ttype_q;
  assign tpdo2_etimer        = etimer_q;
  assign tpdo2_count         = map_cnt_q;
  assign first_mapping_entry = map_ent_q;
endmodule

// File: emo_pkg.sv
/*
 Constants for the encoder motion object set: object indices, sub-indices,
 reset values, filter delays, abort codes and clock timing.
 Assumes a 25 MHz core clock and an object access port fed by an SDO server.
*/
package emo_pkg;
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned SPD_DLY0_MS = 5;
  localparam int unsigned SPD_DLY1_MS = 50;
  localparam int unsigned SPD_DLY2_MS = 500;
  localparam int unsigned ACC_DLY0_MS = 40;
  localparam int unsigned ACC_DLY1_MS = 120;
  localparam int unsigned ACC_DLY2_MS = 750;
  localparam logic [7:0] FILT_MAX     = 8'h02;

  localparam logic [15:0] OBJ_TPDO2_COMM = 16'h1801;
  localparam logic [15:0] OBJ_TPDO2_MAP  = 16'h1a01;
  localparam logic [15:0] OBJ_VPOS       = 16'h2000;
  localparam logic [15:0] OBJ_VOPWORD    = 16'h2100;
  localparam logic [15:0] OBJ_VSTEPS     = 16'h2101;
  localparam logic [15:0] OBJ_SPD_CTRL   = 16'h3010;
  localparam logic [15:0] OBJ_SPD32      = 16'h3011;
  localparam logic [15:0] OBJ_ACC_CTRL   = 16'h3020;
  localparam logic [15:0] OBJ_ACC32      = 16'h3021;
  localparam logic [15:0] OBJ_LEGACY     = 16'h3030;
  localparam logic [15:0] OBJ_LOADER     = 16'h4000;
  localparam logic [15:0] OBJ_OPWORD     = 16'h6000;
  localparam logic [15:0] OBJ_STEPS      = 16'h6001;
  localparam logic [15:0] OBJ_RANGE      = 16'h6002;
  localparam logic [15:0] OBJ_PRESET     = 16'h6003;
  localparam logic [15:0] OBJ_POS        = 16'h6004;
  localparam logic [15:0] OBJ_SPD16      = 16'h6030;
  localparam logic [3:0]  COMM_AREA      = 4'h1;

  localparam logic [7:0] SUB_0      = 8'h00;
  localparam logic [7:0] SUB_1      = 8'h01;
  localparam logic [7:0] SUB_2      = 8'h02;
  localparam logic [7:0] SUB_ETIMER = 8'h05;
  localparam logic [7:0] CTRL_SUBS  = 8'h02;
  localparam logic [7:0] SPD16_SUBS = 8'h01;
  localparam logic [7:0] MAP_MAX    = 8'h01;

  localparam logic [31:0] LEGACY_KEY = 32'h4711_1147;
  localparam int unsigned OPW_DIR    = 0;
  localparam int unsigned OPW_SCALE  = 2;
  localparam logic [15:0] OPW_MASK   = 16'hf00f;
  localparam logic [15:0] OPW_RESET  = 16'h0000;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [6:0]  LOADER_NODE  = 7'h01;
  localparam logic [7:0]  LOADER_BAUD  = 8'h03;

  localparam logic [31:0] AB_NONE   = 32'h0000_0000;
  localparam logic [31:0] AB_WO     = 32'h0601_0001;
  localparam logic [31:0] AB_RO     = 32'h0601_0002;
  localparam logic [31:0] AB_NO_OBJ = 32'h0602_0000;
  localparam logic [31:0] AB_NO_SUB = 32'h0609_0011;
  localparam logic [31:0] AB_RANGE  = 32'h0609_0030;
  localparam logic [31:0] AB_STATE  = 32'h0800_0022;

  typedef enum logic [1:0] {LD_RUN, LD_ERASE, LD_RESET} emo_ld_state_t;
endpackage

// File: emo_rate_if.sv
/*
 Link between the object logic and one rate measurement unit.
 Assumes both ends run on core_clk; the tick is a one-cycle millisecond pulse.
*/
`timescale 1ns/1ps
interface emo_rate_if;
  logic        ms_tick;
  logic        en;
  logic [7:0]  mode;
  logic [31:0] din;
  logic [31:0] dout;
  logic        upd;

  modport src  (output ms_tick, en, mode, din, input dout, upd);
  modport meas (input ms_tick, en, mode, din, output dout, upd);
endinterface

// File: emo_rate.sv
/*
 Rate measurement unit: differentiates its input over a filter window and
 reports the change per second. Assumes mode is never above two.
*/
`timescale 1ns/1ps
module emo_rate #(
  parameter int unsigned DLY0 = 1,
  parameter int unsigned DLY1 = 1,
  parameter int unsigned DLY2 = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Measurement link
  emo_rate_if.meas rif
);
  import emo_pkg::*;

  logic [9:0]  ms_q;
  logic [31:0] prev_q;
  logic [31:0] dout_q;
  logic        primed_q;
  logic        upd_q;

  wire [9:0] win = (rif.mode == 8'h00) ? 10'(DLY0) :
                   (rif.mode == 8'h01) ? 10'(DLY1) : 10'(DLY2);
  wire win_end = rif.ms_tick && (ms_q >= win - 10'd1);
  wire signed [32:0] delta = $signed({rif.din[31], rif.din}) -
                             $signed({prev_q[31], prev_q});
  wire signed [43:0] prod = 44'(delta) * $signed(44'(MS_PER_S));
  wire signed [43:0] quo  = prod / $signed({34'h0, win});
  // Saturation keeps a fast shaft from wrapping the sign of the result.
  wire ovf = (quo[43:31] != {13{quo[43]}});
  wire [31:0] sat = ovf ? (quo[43] ? 32'h8000_0000 : 32'h7fff_ffff)
                        : quo[31:0];

  always_ff @(posedge core_clk) begin
    if (srst || !rif.en) begin
      ms_q     <= 10'h000;
      prev_q   <= 32'h0000_0000;
      dout_q   <= 32'h0000_0000;
      primed_q <= 1'b0;
      upd_q    <= 1'b0;
    end else begin
      upd_q <= win_end && primed_q;
      if (rif.ms_tick) begin
        ms_q <= win_end ? 10'h000 : ms_q + 10'd1;
      end
      if (win_end) begin
        prev_q   <= rif.din;
        primed_q <= 1'b1;
        if (primed_q) begin
          dout_q <= sat;
        end
      end
    end
  end

  assign rif.dout = dout_q;
  assign rif.upd  = upd_q;
endmodule

// File: emo_top_assertions.sv
/* Checker for the object port and status outputs of emo_top.
   Assumes binding from the testbench top file. */
`timescale 1ns/1ps
module emo_top_assertions
  import emo_pkg::*;
#(
  parameter logic [31:0] LOADER_KEY = 32'h1234_5678
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        od_req,
  input wire logic        od_write,
  input wire logic [15:0] od_index,
  input wire logic [7:0]  od_sub,
  input wire logic [31:0] od_wdata,
  input wire logic        od_ack,
  input wire logic        od_abort,
  input wire logic [31:0] od_abort_code,
  input wire logic        loader_mode,
  input wire logic        nv_erase,
  input wire logic        dev_reset_req,
  input wire logic [6:0]  node_id,
  input wire logic [7:0]  baud_code,
  input wire logic [31:0] speed_32,
  input wire logic [15:0] speed_16,
  input wire logic [7:0]  tpdo2_count,
  input wire logic [31:0] first_mapping_entry
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence wr_s;
    od_req && od_write && !loader_mode;
  endsequence
  sequence key_s;
    od_index == OBJ_LOADER && od_wdata == LOADER_KEY;
  endsequence
  a_ack_one_cycle: assert property (od_req |=> od_ack)
    else $error("ack missing after request");
  a_ack_no_req: assert property (!od_req |=> !od_ack)
    else $error("ack without request");
  a_abort_coded: assert property (od_abort
    |-> od_ack && od_abort_code != 0) else $error("abort without code");
  a_filter_range: assert property (wr_s ##0 (od_sub == SUB_2
    && od_wdata[7:0] > FILT_MAX
    && (od_index == OBJ_SPD_CTRL || od_index == OBJ_ACC_CTRL))
    |=> od_abort && od_abort_code == AB_RANGE) else $error("filter accepted");
  a_loader_erase: assert property (wr_s ##0 key_s
    |=> nv_erase ##1 (dev_reset_req && !nv_erase)) else $error("no erase");
  a_loader_ids: assert property (loader_mode && $past(loader_mode)
    |-> node_id == LOADER_NODE && baud_code == LOADER_BAUD)
    else $error("loader ids wrong");
  a_spd_sat: assert property ($signed(speed_32) > 32767
    |=> speed_16 == 16'h7fff) else $error("speed not saturated");
  a_pos_ro: assert property (wr_s ##0 od_index == OBJ_POS
    |=> od_abort_code == AB_RO) else $error("position written");
  a_map_lock: assert property (wr_s ##0 (od_index == OBJ_TPDO2_MAP
    && od_sub == SUB_1 && tpdo2_count != 0)
    |=> od_abort_code == AB_STATE && $stable(first_mapping_entry))
    else $error("mapping changed while live");
endmodule

// File: emo_master_model.sv
/* Network master model: one object access per call and the speed
   mapping sequence. Assumes an answer one cycle after each request. */
`timescale 1ns/1ps
module emo_master_model
  import emo_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        od_ack,
  input  wire logic [31:0] od_abort_code,
  input  wire logic [31:0] od_rdata,
  output logic             od_req,
  output logic             od_write,
  output logic             od_restore,
  output logic [15:0]      od_index,
  output logic [7:0]       od_sub,
  output logic [31:0]      od_wdata
);
  initial begin
    {od_req, od_write, od_restore, od_index, od_sub, od_wdata} = '0;
  end
  // A missing answer is reported as an impossible abort code.
  task automatic acc(input logic w, input logic r, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d,
                     output logic [31:0] rd, output logic [31:0] ab);
    @(negedge core_clk);
    {od_req, od_write, od_restore} = {1'b1, w, r};
    {od_index, od_sub, od_wdata} = {i, s, d};
    @(negedge core_clk);
    {od_req, od_restore} = 2'b00;
    rd = od_rdata;
    ab = od_ack ? od_abort_code : 32'hdead_dead;
  endtask
  task automatic map_speed(output logic [31:0] ab);
    logic [15:0] ix [6] = '{OBJ_TPDO2_COMM, OBJ_TPDO2_COMM, OBJ_TPDO2_MAP,
                            OBJ_TPDO2_MAP, OBJ_TPDO2_MAP, OBJ_SPD_CTRL};
    logic [7:0]  sx [6] = '{SUB_2, SUB_ETIMER, SUB_0, SUB_1, SUB_0, SUB_1};
    logic [31:0] dx [6] = '{32'hfe, 32'h64, 32'h0, 32'h6030_0110, 32'h1, 32'h1};
    logic [31:0] rd;
    logic [31:0] a;
    ab = AB_NONE;
    for (int k = 0; k < 6; k++) begin
      acc(1'b1, 1'b0, ix[k], sx[k], dx[k], rd, a);
      ab = ab | a;
    end
  endtask
endmodule

// File: emo_top_tb.sv
/* Self-checking bench for emo_top through its object port.
   Assumes emo_master_model and the checker are compiled first. */
`timescale 1ns/1ps
module emo_top_tb;
  import emo_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        app_valid = 1'b1;
  logic [31:0] raw_pos = 32'h0;
  logic [31:0] step = 32'h0;
  logic        od_req, od_write, od_restore, od_ack, od_abort, loader_mode;
  logic        nv_erase, dev_reset_req, legacy_compat_mode;
  logic [15:0] od_index, speed_16, tpdo2_etimer;
  logic [7:0]  od_sub, baud_code, tpdo2_ttype, tpdo2_count;
  logic [6:0]  node_id;
  logic [31:0] od_wdata, od_rdata, od_abort_code, speed_32, first_mapping_entry;
  logic [31:0] rd_x, ab_x;
  int          n_fail = 0;
  int          n_tests = 0;
  always #20 core_clk = ~core_clk;
  always @(negedge core_clk) raw_pos <= raw_pos + step;
  emo_top #(.MS_CYC(10)) DUT (.cfg_node_id(7'h05), .cfg_baud(8'h04),
    .position_out(), .accel_32(), .*);
  emo_master_model PM (.*);
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t status output", $time);
    end
  endtask
  task automatic t(input logic w, input logic [15:0] i, input logic [7:0] s,
                   input logic [31:0] d, input logic [31:0] er,
                   input logic [31:0] ea);
    logic [31:0] rd, ab;
    PM.acc(w, 1'b0, i, s, d, rd, ab);
    n_tests++;
    if (ab !== ea || (!w && ea == AB_NONE && rd !== er)) begin
      n_fail++;
      $display("MISMATCH t=%0t obj %h.%h rd %h ab %h", $time, i, s, rd, ab);
    end
  endtask
  task automatic do_reset();
    srst = 1'b1;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic bump(input logic [31:0] n);
    @(negedge core_clk) step <= n;
    @(negedge core_clk) step <= 32'h0;
  endtask
  initial begin
    #(40 * 20000);
    n_fail++;
    complete_run();
  end
  initial begin
    do_reset();
    chk(node_id === 7'h05 && baud_code === 8'h04 && !loader_mode);
    t(0, OBJ_SPD_CTRL, SUB_1, 0, 0, AB_NONE);
    t(0, OBJ_ACC_CTRL, SUB_1, 0, 0, AB_NONE);
    t(0, OBJ_OPWORD, SUB_0, 0, OPW_RESET, AB_NONE);
    t(0, OBJ_PRESET, SUB_0, 0, PRESET_RESET, AB_NONE);
    t(0, OBJ_LEGACY, SUB_1, 0, 0, AB_NONE);
    for (int k = 3; k >= 0; k--) begin
      t(1, OBJ_SPD_CTRL, SUB_2, k, 0, k > 2 ? AB_RANGE : AB_NONE);
      t(1, OBJ_ACC_CTRL, SUB_2, k, 0, k > 2 ? AB_RANGE : AB_NONE);
    end
    t(1, OBJ_ACC_CTRL, SUB_2, 3, 0, AB_RANGE);
    t(0, OBJ_ACC_CTRL, SUB_2, 0, 0, AB_NONE);
    PM.acc(1, 1, OBJ_LEGACY, SUB_1, 1, rd_x, ab_x);
    chk(ab_x === AB_NONE && legacy_compat_mode === 1'b1);
    t(1, OBJ_LEGACY, SUB_1, 0, 0, AB_STATE);
    chk(legacy_compat_mode === 1'b1);
    t(1, OBJ_LEGACY, SUB_0, LEGACY_KEY, 0, AB_NONE);
    t(1, OBJ_LEGACY, SUB_1, 0, 0, AB_NONE);
    chk(legacy_compat_mode === 1'b0);
    t(1, OBJ_LEGACY, SUB_1, 1, 0, AB_NONE);
    chk(legacy_compat_mode === 1'b1);
    t(1, OBJ_OPWORD, SUB_0, 32'hffff, 0, AB_NONE);
    t(0, OBJ_OPWORD, SUB_0, 0, 32'hf00f, AB_NONE);
    t(0, OBJ_VOPWORD, SUB_0, 0, 32'h1, AB_NONE);
    t(1, OBJ_OPWORD, SUB_0, 32'h1, 0, AB_NONE);
    t(1, OBJ_PRESET, SUB_0, 32'h100, 0, AB_NONE);
    bump(5);
    t(0, OBJ_POS, SUB_0, 0, 32'hfb, AB_NONE);
    t(0, OBJ_VPOS, SUB_0, 0, 32'hfb, AB_NONE);
    t(1, OBJ_VOPWORD, SUB_0, 0, 0, AB_NONE);
    t(0, OBJ_OPWORD, SUB_0, 0, 32'h0, AB_NONE);
    t(1, OBJ_STEPS, SUB_0, 32'h2_0000, 0, AB_NONE);
    t(0, OBJ_VSTEPS, SUB_0, 0, 32'h2_0000, AB_NONE);
    t(1, OBJ_RANGE, SUB_0, 32'h1000, 0, AB_NONE);
    t(0, OBJ_RANGE, SUB_0, 0, 32'h1000, AB_NONE);
    t(1, OBJ_OPWORD, SUB_0, 32'h4, 0, AB_NONE);
    t(1, OBJ_PRESET, SUB_0, 32'h100, 0, AB_NONE);
    bump(5);
    t(0, OBJ_POS, SUB_0, 0, 32'h10a, AB_NONE);
    t(1, OBJ_POS, SUB_0, 0, 0, AB_RO);
    t(1, OBJ_OPWORD, SUB_0, 32'h0, 0, AB_NONE);
    @(negedge core_clk) step <= 32'h1;
    t(1, OBJ_SPD_CTRL, SUB_1, 1, 0, AB_NONE);
    repeat (250) @(negedge core_clk);
    t(0, OBJ_SPD32, SUB_0, 0, 32'd10000, AB_NONE);
    t(0, OBJ_SPD16, SUB_1, 0, 32'd10000, AB_NONE);
    t(1, OBJ_SPD32, SUB_0, 0, 0, AB_RO);
    @(negedge core_clk) step <= 32'h4;
    repeat (250) @(negedge core_clk);
    t(0, OBJ_SPD16, SUB_1, 0, 32'h7fff, AB_NONE);
    t(1, OBJ_ACC_CTRL, SUB_1, 1, 0, AB_NONE);
    t(1, OBJ_ACC32, SUB_0, 0, 0, AB_RO);
    repeat (450) @(negedge core_clk);
    step <= 32'h0;
    repeat (450) @(negedge core_clk);
    // Speed fell by 40000 steps/s inside one 40 ms window: -1000000.
    t(0, OBJ_ACC32, SUB_0, 0, 32'hfff0_bdc0, AB_NONE);
    PM.map_speed(ab_x);
    chk(ab_x === AB_NONE);
    chk({tpdo2_ttype, tpdo2_etimer, tpdo2_count} === 32'hfe_0064_01);
    chk(first_mapping_entry === 32'h6030_0110);
    t(1, OBJ_TPDO2_MAP, SUB_1, 0, 0, AB_STATE);
    t(0, OBJ_LOADER, SUB_0, 0, 0, AB_WO);
    t(1, OBJ_LOADER, SUB_0, 0, 0, AB_RANGE);
    t(1, OBJ_LOADER, SUB_0, 32'h1234_5678, 0, AB_NONE);
    chk(nv_erase === 1'b1);
    @(negedge core_clk);
    chk(dev_reset_req === 1'b1);
    app_valid = 1'b0;
    do_reset();
    chk(loader_mode === 1'b1 && node_id === 7'h01);
    chk(baud_code === 8'h03);
    t(0, OBJ_POS, SUB_0, 0, 0, AB_NO_OBJ);
    complete_run();
  end
endmodule
bind emo_top emo_top_assertions #(.LOADER_KEY(LOADER_KEY)) u_chk (.*);
